// >>> hw/e1_frame_gen_pkg.sv
package e1_frame_gen_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_AUTO_ALARM = 10'h000;
  localparam logic [9:0] IDX_CRC_PATH = 10'h002;
  localparam logic [9:0] IDX_ALARM_OPT = 10'h00e;
  localparam logic [9:0] IDX_GEN_CFG = 10'h040;
  localparam logic [9:0] IDX_ALARM_DIAG = 10'h041;
  localparam logic [9:0] IDX_SPARE_INTL = 10'h042;
  localparam logic [9:0] IDX_EXTRA_BITS = 10'h043;
  localparam logic [9:0] IDX_NAT_SELECT = 10'h046;
  localparam logic [9:0] IDX_NAT_VALUES = 10'h047;
  localparam logic [9:0] IDX_PAYLOAD_CTL = 10'h060;
  localparam logic [9:0] IDX_IDLE_CODE = 10'h061;
  localparam logic [9:0] IDX_GEN_STATUS = 10'h062;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_AUTO_ALARM = {IDX_AUTO_ALARM, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CRC_PATH = {IDX_CRC_PATH, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ALARM_OPT = {IDX_ALARM_OPT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GEN_CFG = {IDX_GEN_CFG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ALARM_DIAG = {IDX_ALARM_DIAG, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SPARE_INTL = {IDX_SPARE_INTL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_EXTRA_BITS = {IDX_EXTRA_BITS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_NAT_SELECT = {IDX_NAT_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_NAT_VALUES = {IDX_NAT_VALUES, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PAYLOAD_CTL = {IDX_PAYLOAD_CTL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IDLE_CODE = {IDX_IDLE_CODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GEN_STATUS = {IDX_GEN_STATUS, 2'b00};

  // Field positions
  localparam int AUTO_REMOTE_ALARM = 3;
  localparam int CRC_PASS_THROUGH = 4;
  localparam int ALTERNATE_ALARM_RULE = 0;
  localparam int OUT_OF_SYNC_ERROR_VALUE = 1;
  localparam int FIFO_REINIT = 7;
  localparam int SIGNALING_ENABLE = 6;
  localparam int DATALINK_ENABLE = 5;
  localparam int CRC_MULTIFRAME_GEN = 4;
  localparam int BASIC_FRAME_DISABLE = 3;
  localparam int BLOCK_ERROR_REPORT_DISABLE = 2;
  localparam int INTL_BIT_REPLACE_DISABLE = 1;
  localparam int EXTRA_BITS_DISABLE = 0;
  localparam int TRUNK_CONDITIONING = 7;
  localparam int ALIGN_WORD_INVERT = 6;
  localparam int NONALIGN_BIT_INVERT = 5;
  localparam int SIG_ALIGN_INVERT = 4;
  localparam int MANUAL_REMOTE_ALARM = 3;
  localparam int SIG_MULTIFRAME_ALARM_FORCE = 2;
  localparam int SLOT16_ALL_ONES = 1;
  localparam int ALL_SLOTS_ALL_ONES = 0;
  localparam int SPARE_BIT1 = 7;
  localparam int SPARE_BIT0 = 6;
  localparam int EXTRA_X0 = 0;
  localparam int EXTRA_X1 = 1;
  localparam int EXTRA_X2 = 3;
  localparam int NAT_POS_LSB = 5;
  localparam int NAT_EN_MSB = 7;
  localparam int NAT_VAL_MSB = 3;
  localparam int PAYLOAD_CTRL_ENABLE = 0;
  localparam int SIG_ALARM_FORCE_EN = 1;

  // Bit positions inside an octet; line bit 1 is the msb
  localparam int POS_INTL = 7;
  localparam int POS_FIXED_ONE = 6;
  localparam int POS_REMOTE_ALARM = 5;
  localparam int POS_NAT_FIRST = 4;
  localparam int POS_EXTRA_A = 4;
  localparam int POS_SIG_ALARM = 2;
  localparam int POS_EXTRA_B = 2;
  localparam int POS_EXTRA_C = 1;
  localparam logic [2:0] NAT_POS_LAST = 3'h4;

  // Frame structure
  localparam logic [4:0] TS_ALIGN = 5'h00;
  localparam logic [4:0] TS_SIGNALING = 5'h10;
  localparam logic [4:0] TS_LAST = 5'h1f;
  localparam logic [3:0] FRAME_SMF1_LAST = 4'h7;
  localparam logic [3:0] FRAME_SMF2_LAST = 4'hf;
  localparam logic [3:0] FRAME_MFA_LAST = 4'hb;
  localparam logic [3:0] FRAME_E1 = 4'hd;
  localparam logic [3:0] FRAME_E2 = 4'hf;
  localparam logic [6:0] ALIGN_WORD = 7'h1b;
  localparam logic [5:0] CRC_MFA_SEQ = 6'h0b;
  localparam logic [3:0] SIG_MFA_NIBBLE = 4'h0;
  localparam logic [3:0] CRC4_POLY = 4'h3;
  localparam logic [7:0] ALL_ONES = 8'hff;

  // Output buffer
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL_COUNT = 3'h4;

  typedef struct packed {
    logic [7:0] auto_alarm_config;
    logic [7:0] crc_path_config;
    logic [7:0] remote_alarm_option;
    logic [7:0] generator_config;
    logic [7:0] alarm_diag_control;
    logic [7:0] spare_intl_bits;
    logic [7:0] extra_bits_value;
    logic [7:0] national_bit_select;
    logic [7:0] national_bit_values;
    logic [7:0] payload_control;
    logic [7:0] idle_code;
  } cfg_t;

  localparam cfg_t CFG_RESET = '0;

endpackage

// >>> hw/e1_transmit_frame_generator.sv
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE_01] Unless framing disabled, even frames get X0011011 in slot 0, odd frames bit 2 one.
// [RULE_02] CRC-4 on: odd frames 1-11 first bit carry 001011, even frames carry CRC bits.
// [RULE_03] CRC-4 computed per sub-multiframe, sent in the following sub-multiframe.
// [RULE_04] Pass-through bit keeps incoming CRC bits instead of generated ones.
// [RULE_05] With signaling on, frame 0 slot 16 upper nibble 0000, frames 1-15 from source.
// [RULE_06] Trunk conditioning with payload control puts idle code in slots 1-31, skipping 16 under CAS.
// [RULE_07] Manual remote alarm forces bit 3 of non-alignment frame to one.
// [RULE_08] Auto alarm, standard rule: any of four receive conditions sends alarm.
// [RULE_09] Auto alarm, alternate rule: only frame loss or ALL_SLOTS_ALL_ONES sends alarm; code uses RX_LOSS_OF_FRAME or RX_AIS_DETECTED.
// [RULE_10] Manual and auto both off: alarm bit sent as zero.
// [RULE_11] Block error reporting: frames 13/15 first bit zero on sub-multiframe I/II CRC error.
// [RULE_12] Without receive CRC multiframe sync, both error bits take a control bit value.
// [RULE_13] Signaling on: frame 0 slot 16 bit 6 is multiframe alarm, forceable to 0 or 1.
// [RULE_14] Intl replacement with CRC-4 off: alignment frames spare bit 1, others spare bit 0.
// [RULE_15] CRC-4 on with reporting off: frames 13 and 15 carry spare bits.
// [RULE_16] Four enabled national values replace the national bit chosen by a selector.
// [RULE_17] Signaling on, extras enabled: slot 16 frame 0 bits 4, 6, 7 from extra field; code then overwrites bit 6 with the multiframe alarm.
// [RULE_18] Diagnostic inverts alignment word to 1100100.
// [RULE_19] Diagnostic inverts the fixed bit 2 of non-alignment frames to zero.
// [RULE_20] Diagnostic inverts signaling alignment nibble to 1111.
// [RULE_21] All-ones overrides all: one control slot 16 only, another every slot.
// [RULE_22] Outgoing stream buffered in a FIFO; refresh bit reinitialises it.
// [RULE_23] Count 32 slots per frame, 16 frames per multiframe, parity and halves aligned.
// [RULE_24] Configuration changes apply at the next frame boundary.
module e1_transmit_frame_generator
  import e1_frame_gen_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [e1_frame_gen_pkg::ADDR_W-1:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] TRANSMIT_SYSTEM_DATA,
  input wire logic SYS_VALID,
  output logic SYS_READY,
  input wire logic [7:0] SIGNALING_DATA,
  input wire logic RX_LOSS_OF_FRAME,
  input wire logic RX_AIS_DETECTED,
  input wire logic RX_CRC_INTERWORKING,
  input wire logic RX_OFFLINE_OOF,
  input wire logic RX_CRC_MF_SYNC,
  input wire logic RX_SMF1_CRC_ERROR,
  input wire logic RX_SMF2_CRC_ERROR,
  input wire logic RX_SIG_MF_ALARM,
  output logic [7:0] LINE_DATA,
  output logic LINE_VALID,
  input wire logic LINE_READY
);
  import e1_frame_gen_pkg::*;

  typedef struct packed {
    cfg_t cfg;
    cfg_t act;
    logic [4:0] ts;
    logic [3:0] frame;
    logic [3:0] crc_acc;
    logic [3:0] crc_out;
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [1:0] wr_ptr;
    logic [1:0] rd_ptr;
    logic [2:0] count;
    logic sys_ready;
    logic [7:0] line_data;
    logic line_valid;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s;
  state_t next_s;

  // Serial CRC-4 over one octet, msb first
  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [7:0] d);
    logic [3:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[3] ^ d[i];
      r = {r[2:0], 1'b0} ^ (fb ? CRC4_POLY : 4'h0);
    end
    return r;
  endfunction

  // Next-state logic: register bus, frame build, CRC, buffer
  always_comb begin
    logic [7:0] b;
    logic [7:0] crc_in;
    logic [7:0] rd;
    logic accept;
    logic pop;
    logic cas;
    logic crc_on;
    logic intl_on;
    logic even;
    logic rai;
    logic sig_alarm;
    logic [2:0] nat_pos;
    logic [1:0] sub;
    b = 8'h00;
    crc_in = 8'h00;
    rd = 8'h00;
    accept = 1'b0;
    pop = 1'b0;
    cas = 1'b0;
    crc_on = 1'b0;
    intl_on = 1'b0;
    even = 1'b0;
    rai = 1'b0;
    sig_alarm = 1'b0;
    nat_pos = 3'h0;
    sub = 2'h0;
    next_s = s;

    // APB: one wait state, answer registered
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    if (PSEL && PENABLE && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      case (PADDR)
        ADDR_AUTO_ALARM: rd = s.cfg.auto_alarm_config;
        ADDR_CRC_PATH: rd = s.cfg.crc_path_config;
        ADDR_ALARM_OPT: rd = s.cfg.remote_alarm_option;
        ADDR_GEN_CFG: rd = s.cfg.generator_config;
        ADDR_ALARM_DIAG: rd = s.cfg.alarm_diag_control;
        ADDR_SPARE_INTL: rd = s.cfg.spare_intl_bits;
        ADDR_EXTRA_BITS: rd = s.cfg.extra_bits_value;
        ADDR_NAT_SELECT: rd = s.cfg.national_bit_select;
        ADDR_NAT_VALUES: rd = s.cfg.national_bit_values;
        ADDR_PAYLOAD_CTL: rd = s.cfg.payload_control;
        ADDR_IDLE_CODE: rd = s.cfg.idle_code;
        ADDR_GEN_STATUS: next_s.prdata = {20'h0_0000, s.count, s.frame, s.ts};
        default: next_s.pslverr = 1'b1;
      endcase
      if (PADDR != ADDR_GEN_STATUS) begin
        next_s.prdata[7:0] = rd;
      end
    end

    // Refresh bit clears itself after one cycle
    if (s.cfg.generator_config[FIFO_REINIT]) begin
      next_s.cfg.generator_config[FIFO_REINIT] = 1'b0;
    end

    // Register writes take effect at the completing edge
    if (PSEL && PENABLE && s.pready && PWRITE) begin
      case (PADDR)
        ADDR_AUTO_ALARM: next_s.cfg.auto_alarm_config = PWDATA[7:0];
        ADDR_CRC_PATH: next_s.cfg.crc_path_config = PWDATA[7:0];
        ADDR_ALARM_OPT: next_s.cfg.remote_alarm_option = PWDATA[7:0];
        ADDR_GEN_CFG: next_s.cfg.generator_config = PWDATA[7:0];
        ADDR_ALARM_DIAG: next_s.cfg.alarm_diag_control = PWDATA[7:0];
        ADDR_SPARE_INTL: next_s.cfg.spare_intl_bits = PWDATA[7:0];
        ADDR_EXTRA_BITS: next_s.cfg.extra_bits_value = PWDATA[7:0];
        ADDR_NAT_SELECT: next_s.cfg.national_bit_select = PWDATA[7:0];
        ADDR_NAT_VALUES: next_s.cfg.national_bit_values = PWDATA[7:0];
        ADDR_PAYLOAD_CTL: next_s.cfg.payload_control = PWDATA[7:0];
        ADDR_IDLE_CODE: next_s.cfg.idle_code = PWDATA[7:0];
        default: ;
      endcase
    end

    // Mode decode from the frame-aligned copy
    cas = s.act.generator_config[SIGNALING_ENABLE] && s.act.generator_config[DATALINK_ENABLE];
    crc_on = s.act.generator_config[CRC_MULTIFRAME_GEN];
    intl_on = !s.act.generator_config[INTL_BIT_REPLACE_DISABLE];
    even = !s.frame[0];
    sub = s.frame[2:1];
    nat_pos = s.act.national_bit_select[NAT_POS_LSB +: 3];

    // Remote alarm source
    if (s.act.alarm_diag_control[MANUAL_REMOTE_ALARM]) begin
      rai = 1'b1; // RULE_07
    end else if (s.act.auto_alarm_config[AUTO_REMOTE_ALARM]) begin
      if (s.act.remote_alarm_option[ALTERNATE_ALARM_RULE]) begin
        rai = RX_LOSS_OF_FRAME || RX_AIS_DETECTED; // RULE_09
      end else begin
        rai = RX_LOSS_OF_FRAME || RX_AIS_DETECTED || RX_CRC_INTERWORKING || RX_OFFLINE_OOF; // RULE_08
      end
    end else begin
      rai = 1'b0; // RULE_10
    end

    // Signaling multiframe alarm, optionally forced
    if (s.act.payload_control[SIG_ALARM_FORCE_EN]) begin
      sig_alarm = s.act.alarm_diag_control[SIG_MULTIFRAME_ALARM_FORCE]; // RULE_13
    end else begin
      sig_alarm = RX_SIG_MF_ALARM; // RULE_13
    end

    // Build the outgoing octet
    b = TRANSMIT_SYSTEM_DATA;
    if (s.act.payload_control[PAYLOAD_CTRL_ENABLE] && s.act.alarm_diag_control[TRUNK_CONDITIONING]
        && s.ts != TS_ALIGN && !(cas && s.ts == TS_SIGNALING)) begin
      b = s.act.idle_code; // RULE_06
    end
    if (cas && s.ts == TS_SIGNALING) begin
      if (s.frame == 4'h0) begin
        b[7:4] = s.act.alarm_diag_control[SIG_ALIGN_INVERT] ? ~SIG_MFA_NIBBLE : SIG_MFA_NIBBLE; // RULE_05 RULE_20
        if (!s.act.generator_config[EXTRA_BITS_DISABLE]) begin
          b[POS_EXTRA_A] = s.act.extra_bits_value[EXTRA_X2]; // RULE_17
          b[POS_EXTRA_B] = s.act.extra_bits_value[EXTRA_X1]; // RULE_17
          b[POS_EXTRA_C] = s.act.extra_bits_value[EXTRA_X0]; // RULE_17
        end
        b[POS_SIG_ALARM] = sig_alarm; // RULE_13
      end else begin
        b = SIGNALING_DATA; // RULE_05
      end
    end
    if (s.ts == TS_ALIGN && !s.act.generator_config[BASIC_FRAME_DISABLE]) begin
      if (even) begin
        b[6:0] = s.act.alarm_diag_control[ALIGN_WORD_INVERT] ? ~ALIGN_WORD : ALIGN_WORD; // RULE_01 RULE_18
      end else begin
        b[POS_FIXED_ONE] = !s.act.alarm_diag_control[NONALIGN_BIT_INVERT]; // RULE_01 RULE_19
        b[POS_REMOTE_ALARM] = rai; // RULE_07
        if (nat_pos <= NAT_POS_LAST && s.act.national_bit_values[NAT_EN_MSB - int'(sub)]) begin
          b[POS_NAT_FIRST - int'(nat_pos)] = s.act.national_bit_values[NAT_VAL_MSB - int'(sub)]; // RULE_16
        end
      end
      if (intl_on) begin
        if (!crc_on) begin
          b[POS_INTL] = even ? s.act.spare_intl_bits[SPARE_BIT1] : s.act.spare_intl_bits[SPARE_BIT0]; // RULE_14
        end else if (even) begin
          if (!s.act.crc_path_config[CRC_PASS_THROUGH]) begin
            b[POS_INTL] = s.crc_out[3 - int'(sub)]; // RULE_02 RULE_04
          end
        end else if (s.frame <= FRAME_MFA_LAST) begin
          b[POS_INTL] = CRC_MFA_SEQ[5 - int'(s.frame[3:1])]; // RULE_02
        end else if (s.act.generator_config[BLOCK_ERROR_REPORT_DISABLE]) begin
          b[POS_INTL] = (s.frame == FRAME_E1) ? s.act.spare_intl_bits[SPARE_BIT1]
                                              : s.act.spare_intl_bits[SPARE_BIT0]; // RULE_15
        end else if (!RX_CRC_MF_SYNC) begin
          b[POS_INTL] = s.act.remote_alarm_option[OUT_OF_SYNC_ERROR_VALUE]; // RULE_12
        end else begin
          b[POS_INTL] = (s.frame == FRAME_E1) ? !RX_SMF1_CRC_ERROR : !RX_SMF2_CRC_ERROR; // RULE_11
        end
      end
    end

    // CRC covers the octet with its check-bit position zeroed
    crc_in = b;
    if (s.ts == TS_ALIGN && even) begin
      crc_in[POS_INTL] = 1'b0;
    end

    // All-ones insertion has the last word
    if (s.act.alarm_diag_control[ALL_SLOTS_ALL_ONES]
        || (s.act.alarm_diag_control[SLOT16_ALL_ONES] && s.ts == TS_SIGNALING)) begin
      b = ALL_ONES; // RULE_21
    end

    // Line side: output stage refills from the buffer
    pop = (s.count != 3'h0) && (!s.line_valid || LINE_READY);
    if (pop) begin
      next_s.line_data = s.mem[s.rd_ptr];
      next_s.line_valid = 1'b1;
      next_s.rd_ptr = s.rd_ptr + 2'h1;
    end else if (LINE_READY) begin
      next_s.line_valid = 1'b0;
    end

    // System side: take one octet per slot
    accept = SYS_VALID && s.sys_ready && !s.cfg.generator_config[FIFO_REINIT];
    if (accept) begin
      next_s.mem[s.wr_ptr] = b; // RULE_22
      next_s.wr_ptr = s.wr_ptr + 2'h1;
      next_s.crc_acc = crc_step(s.crc_acc, crc_in); // RULE_03
      next_s.ts = s.ts + 5'h01; // RULE_23
      if (s.ts == TS_LAST) begin
        next_s.frame = s.frame + 4'h1; // RULE_23
        next_s.act = next_s.cfg; // RULE_24
        if (s.frame == FRAME_SMF1_LAST || s.frame == FRAME_SMF2_LAST) begin
          next_s.crc_out = crc_step(s.crc_acc, crc_in); // RULE_03
          next_s.crc_acc = 4'h0; // RULE_03
        end
      end
    end
    next_s.count = s.count + {2'b00, accept} - {2'b00, pop};

    // Refresh empties the buffer and drops what it held
    if (s.cfg.generator_config[FIFO_REINIT]) begin
      next_s.wr_ptr = 2'h0; // RULE_22
      next_s.rd_ptr = 2'h0; // RULE_22
      next_s.count = 3'h0; // RULE_22
      next_s.line_valid = 1'b0;
    end
    next_s.sys_ready = next_s.count < FIFO_FULL_COUNT;
  end

  // State register with synchronous reset
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.act <= CFG_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign SYS_READY = s.sys_ready;
  assign LINE_DATA = s.line_data;
  assign LINE_VALID = s.line_valid;

endmodule
`default_nettype wire

// >>> dv/e1_frame_gen_sva.sv
`timescale 1ns/1ps
`default_nettype none
module e1_frame_gen_sva
  import e1_frame_gen_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [e1_frame_gen_pkg::ADDR_W-1:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [7:0] LINE_DATA,
  input wire logic LINE_VALID,
  input wire logic LINE_READY
);
  logic [7:0] gc, dg, sp, aa, pc, idle;
  logic [8:0] idx;
  logic [6:0] quiet;
  logic lost, wr, take, ok;
  // Completed writes and consumed octets
  assign wr = PSEL && PENABLE && PWRITE && PREADY;
  assign take = LINE_VALID && LINE_READY;
  assign ok = take && quiet == 7'h40 && !lost;
  // Register shadow, line position, settle count since last write
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      {gc, dg, sp, aa, pc, idle} <= '0;
      idx <= 9'h000;
      quiet <= 7'h00;
      lost <= 1'b0;
    end else begin
      if (wr) begin
        quiet <= 7'h00;
        if (PADDR == ADDR_GEN_CFG) gc <= PWDATA[7:0];
        if (PADDR == ADDR_ALARM_DIAG) dg <= PWDATA[7:0];
        if (PADDR == ADDR_SPARE_INTL) sp <= PWDATA[7:0];
        if (PADDR == ADDR_AUTO_ALARM) aa <= PWDATA[7:0];
        if (PADDR == ADDR_PAYLOAD_CTL) pc <= PWDATA[7:0];
        if (PADDR == ADDR_IDLE_CODE) idle <= PWDATA[7:0];
        if (PADDR == ADDR_GEN_CFG && PWDATA[7]) lost <= 1'b1;
      end else if (take && quiet != 7'h40) begin
        quiet <= quiet + 7'h01;
      end
      if (take) idx <= idx + 9'h001;
    end
  end
  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  chk_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready longer than one cycle");
  chk_one_wait: assert property ($rose(PSEL && PENABLE) |-> !PREADY ##1 PREADY) else $error("wait state count");
  chk_err_data: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0) else $error("error read data not zero");
  chk_line_hold: assert property (LINE_VALID && !LINE_READY && !PSEL && !lost |=> LINE_VALID && $stable(LINE_DATA))
    else $error("line octet dropped while stalled");
  chk_align_word: assert property (ok && idx[5:0] == 6'h00 && !gc[3] && !dg[0] |->
    LINE_DATA[6:0] == (dg[6] ? 7'h64 : ALIGN_WORD)) else $error("alignment word");
  chk_fixed_one: assert property (ok && idx[5:0] == 6'h20 && !gc[3] && !dg[0] |->
    LINE_DATA[POS_FIXED_ONE] == !dg[5]) else $error("fixed bit");
  chk_alarm_bit: assert property (ok && idx[5:0] == 6'h20 && !gc[3] && !dg[0] && (dg[3] || !aa[3]) |->
    LINE_DATA[POS_REMOTE_ALARM] == dg[3]) else $error("remote alarm bit");
  chk_spare_intl: assert property (ok && idx[4:0] == 5'h00 && !gc[3] && !gc[1] && !gc[4] && !dg[0] |->
    LINE_DATA[7] == (idx[5] ? sp[6] : sp[7])) else $error("international bit");
  chk_all_ones: assert property (ok && (dg[0] || (dg[1] && idx[4:0] == TS_SIGNALING)) |->
    LINE_DATA == ALL_ONES) else $error("all ones");
  chk_trunk_idle: assert property (ok && pc[0] && dg[7] && !(gc[6] && gc[5]) && idx[4:0] != 5'h00 && dg[1:0] == 2'h0 |->
    LINE_DATA == idle) else $error("idle code");
  cover property (ok && dg[0]);
  cover property (PREADY && PSLVERR);
  cover property (LINE_VALID && !LINE_READY ##1 LINE_VALID && !LINE_READY);
endmodule
bind e1_transmit_frame_generator e1_frame_gen_sva i_sva (.MCLK, .RST_N, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA,
  .PRDATA, .PREADY, .PSLVERR, .LINE_DATA, .LINE_VALID, .LINE_READY);
`default_nettype wire

// >>> dv/e1_stream_partner.sv
`timescale 1ns/1ps
`default_nettype none
module e1_stream_partner #(
  parameter logic [7:0] PAYLOAD = 8'ha5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] target,
  input wire logic [1:0] pace,
  input wire logic sys_ready,
  output logic [7:0] sys_data,
  output logic sys_valid,
  input wire logic [7:0] line_data,
  input wire logic line_valid,
  output logic line_ready
);
  logic [15:0] sent;
  logic [15:0] nxt;
  logic [7:0] got [$];
  // Source holds octet until taken; idle data toggles; line side prompt, slow or stalled
  always @(posedge clk) begin
    nxt = sent + ((sys_valid && sys_ready) ? 16'h0001 : 16'h0000);
    if (!rst_n) begin
      sent <= 16'h0000;
      sys_valid <= 1'b0;
      sys_data <= 8'h00;
      line_ready <= 1'b0;
    end else begin
      sent <= nxt;
      sys_valid <= nxt < target;
      sys_data <= (nxt < target) ? PAYLOAD : ~sys_data;
      line_ready <= (pace == 2'h0) || (pace == 2'h1 && !line_ready);
      if (line_valid && line_ready) got.push_back(line_data);
    end
  end
endmodule
`default_nettype wire

// >>> dv/e1_transmit_frame_generator_test.sv
`timescale 1ns/1ps
`default_nettype none
module e1_transmit_frame_generator_test;
  import e1_frame_gen_pkg::*;
  localparam logic [7:0] PAY = 8'ha5;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [31:0] PWDATA = '0, PRDATA;
  logic PREADY, PSLVERR, SYS_VALID, SYS_READY, LINE_VALID, LINE_READY;
  logic [7:0] tsd, LINE_DATA;
  logic [7:0] sig = 8'h3c, rx = 8'h00;
  logic [15:0] target = 16'h0000;
  logic [1:0] pace = 2'h0;
  int error_cnt = 0;
  int check_count = 0;
  logic [7:0] sh [logic [11:0]];
  logic [11:0] regs [11] = '{ADDR_AUTO_ALARM, ADDR_CRC_PATH, ADDR_ALARM_OPT, ADDR_GEN_CFG, ADDR_ALARM_DIAG,
    ADDR_SPARE_INTL, ADDR_EXTRA_BITS, ADDR_NAT_SELECT, ADDR_NAT_VALUES, ADDR_PAYLOAD_CTL, ADDR_IDLE_CODE};
  // Clock and watchdog
  always #10 MCLK = ~MCLK;
  initial begin
    #400000;
    error_cnt++;
    stop_test;
  end
  e1_transmit_frame_generator i_dut (.MCLK(MCLK), .RST_N(RST_N), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TRANSMIT_SYSTEM_DATA(tsd), .SYS_VALID(SYS_VALID), .SYS_READY(SYS_READY), .SIGNALING_DATA(sig),
    .RX_LOSS_OF_FRAME(rx[0]), .RX_AIS_DETECTED(rx[1]), .RX_CRC_INTERWORKING(rx[2]), .RX_OFFLINE_OOF(rx[3]),
    .RX_CRC_MF_SYNC(rx[4]), .RX_SMF1_CRC_ERROR(rx[5]), .RX_SMF2_CRC_ERROR(rx[6]), .RX_SIG_MF_ALARM(rx[7]),
    .LINE_DATA(LINE_DATA), .LINE_VALID(LINE_VALID), .LINE_READY(LINE_READY));
  e1_stream_partner #(.PAYLOAD(PAY)) i_far (.clk(MCLK), .rst_n(RST_N), .target(target), .pace(pace),
    .sys_ready(SYS_READY), .sys_data(tsd), .sys_valid(SYS_VALID), .line_data(LINE_DATA),
    .line_valid(LINE_VALID), .line_ready(LINE_READY));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1) @(posedge MCLK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (w && !e) sh[a] = d;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp({31'h0, e}, 32'h0);
  endtask
  // Reference octet from shadow registers; bit 8 marks a computed check bit
  function automatic logic [8:0] expo(input int k);
    logic [7:0] o, gc, dg, nv, ao, sp, ex;
    int fr, ts, j, p;
    fr = (k / 32) % 16;
    ts = k % 32;
    gc = sh[ADDR_GEN_CFG];
    dg = sh[ADDR_ALARM_DIAG];
    nv = sh[ADDR_NAT_VALUES];
    ao = sh[ADDR_ALARM_OPT];
    sp = sh[ADDR_SPARE_INTL];
    ex = sh[ADDR_EXTRA_BITS];
    p = 4 - sh[ADDR_NAT_SELECT][7:5];
    j = (fr % 8) / 2;
    o = PAY;
    if (sh[ADDR_PAYLOAD_CTL][0] && dg[7] && ts != 0 && !(gc[6] && gc[5] && ts == 16)) o = sh[ADDR_IDLE_CODE];
    if (gc[6] && gc[5] && ts == 16) begin
      if (fr != 0) o = sig;
      else begin
        if (!gc[0]) {o[4], o[2], o[1]} = {ex[3], ex[1], ex[0]};
        o[7:4] = dg[4] ? 4'hf : 4'h0;
        o[2] = sh[ADDR_PAYLOAD_CTL][1] ? dg[2] : rx[7];
      end
    end
    if (ts == 0 && !gc[3]) begin
      if (fr % 2 == 0) o[6:0] = dg[6] ? 7'h64 : ALIGN_WORD;
      else begin
        o[6] = !dg[5];
        o[5] = dg[3] | (sh[ADDR_AUTO_ALARM][3] & (rx[0] | rx[1] | (!ao[0] & (rx[2] | rx[3]))));
        if (nv[7-j] && p >= 0) o[p] = nv[3-j];
      end
      if (!gc[1] && !gc[4]) o[7] = sp[fr % 2 == 0 ? 7 : 6];
      else if (!gc[1] && fr % 2 == 1 && fr <= 11) o[7] = CRC_MFA_SEQ[5 - (fr - 1) / 2];
      else if (!gc[1] && fr >= 13 && fr % 2 == 1) o[7] = gc[2] ? sp[fr == 13 ? 7 : 6] :
        (!rx[4] ? ao[1] : !rx[fr == 13 ? 5 : 6]);
    end
    if (dg[0] || (dg[1] && ts == 16)) return {1'b0, ALL_ONES};
    return {gc[4] && !gc[1] && !gc[3] && ts == 0 && fr % 2 == 0 && !sh[ADDR_CRC_PATH][4], o};
  endfunction
  // Flush one frame so new settings apply, then stream and judge n frames
  task automatic go(input int n);
    int b;
    logic [8:0] e;
    logic [7:0] m;
    b = i_far.got.size();
    target <= target + 16'(32 * (n + 1));
    while (i_far.got.size() < b + 32 * (n + 1)) @(posedge MCLK);
    for (int k = b + 32; k < b + 32 * (n + 1); k++) begin
      e = expo(k);
      m = {!e[8], 7'h7f};
      cmp({24'h0, i_far.got[k] & m}, {24'h0, e[7:0] & m});
    end
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 8'h00, r, e);
      cmp(r, 32'h0);
      wr(regs[i], 8'h5a);
      apb(1'b0, regs[i], 8'h00, r, e);
      cmp(r, 32'h5a);
      wr(regs[i], 8'h00);
    end
    apb(1'b0, 12'h004, 8'h00, r, e);
    cmp({e, r[30:0]}, 32'h80000000);
    $display("register test done");
  endtask
  task automatic t_frames;
    go(2);
    wr(ADDR_NAT_SELECT, 8'h40);
    wr(ADDR_NAT_VALUES, 8'hf5);
    wr(ADDR_SPARE_INTL, 8'h80);
    go(8);
    $display("framing test done");
  endtask
  task automatic t_alarm;
    logic [6:0] tab [6] = '{7'h40, 7'h24, 7'h28, 7'h34, 7'h32, 7'h01};
    foreach (tab[i]) begin
      wr(ADDR_ALARM_DIAG, {4'h0, tab[i][6], 3'h0});
      wr(ADDR_AUTO_ALARM, {4'h0, tab[i][5], 3'h0});
      wr(ADDR_ALARM_OPT, {7'h0, tab[i][4]});
      rx <= {4'h0, tab[i][3:0]};
      go(2);
    end
    $display("alarm test done");
  endtask
  task automatic t_crc;
    wr(ADDR_GEN_CFG, 8'h10);
    wr(ADDR_CRC_PATH, 8'h10);
    rx <= 8'h30;
    go(16);
    rx <= 8'h00;
    wr(ADDR_ALARM_OPT, 8'h02);
    go(16);
    wr(ADDR_GEN_CFG, 8'h14);
    go(16);
    $display("crc test done");
  endtask
  task automatic t_cas;
    wr(ADDR_GEN_CFG, 8'h60);
    wr(ADDR_EXTRA_BITS, 8'h03);
    wr(ADDR_PAYLOAD_CTL, 8'h01);
    wr(ADDR_IDLE_CODE, 8'h66);
    wr(ADDR_ALARM_DIAG, 8'h80);
    rx <= 8'h80;
    go(16);
    wr(ADDR_GEN_CFG, 8'h61);
    wr(ADDR_PAYLOAD_CTL, 8'h03);
    wr(ADDR_ALARM_DIAG, 8'hf0);
    go(16);
    wr(ADDR_ALARM_DIAG, 8'h02);
    go(2);
    wr(ADDR_ALARM_DIAG, 8'h01);
    go(1);
    $display("signaling test done");
  endtask
  task automatic t_fifo;
    wr(ADDR_GEN_CFG, 8'h00);
    wr(ADDR_ALARM_DIAG, 8'h80);
    pace <= 2'h1;
    go(2);
    pace <= 2'h2;
    target <= target + 16'h0020;
    @(posedge MCLK);
    while (SYS_READY !== 1'b0) @(posedge MCLK);
    cmp({31'h0, LINE_VALID}, 32'h1);
    wr(ADDR_GEN_CFG, 8'h80);
    repeat (2) @(posedge MCLK);
    cmp({31'h0, LINE_VALID}, 32'h0);
    $display("buffer test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    foreach (regs[i]) sh[regs[i]] = 8'h00;
    repeat (16) @(posedge MCLK);
    RST_N <= 1'b1;
    t_regs;
    t_frames;
    t_alarm;
    t_crc;
    t_cas;
    t_fifo;
    stop_test;
  end
endmodule
`default_nettype wire
